// File: src/stack_pkg.sv
/*
  Shared constants and types of the stack pointer and frame unit: word
  width, register offsets, command codes, reset values and the carrier for
  main-memory requests.
  Assumes a word-addressed main memory and a register port indexed by word.
*/
package stack_pkg;

  // ---------------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------------
  localparam int          WORD_W      = 16;
  localparam int          CNT_W       = 3;
  localparam int          REG_ADDR_W  = 4;
  localparam int          CACHE_DEPTH = 4;
  localparam logic [2:0]  CACHE_FULL  = 3'h4;
  localparam logic [2:0]  OPERANDS    = 3'h2;
  localparam logic [1:0]  MARK_LAST   = 2'h3;

  typedef logic [WORD_W-1:0]     word_t;
  typedef logic [REG_ADDR_W-1:0] reg_addr_t;

  // ---------------------------------------------------------------------
  // Register offsets (word index on the register port)
  // ---------------------------------------------------------------------
  localparam reg_addr_t OFS_DYN_LIMIT   = 4'h0;
  localparam reg_addr_t OFS_DATA_BASE   = 4'h1;
  localparam reg_addr_t OFS_STACK_LIMIT = 4'h2;
  localparam reg_addr_t OFS_FRAME_BASE  = 4'h3;
  localparam reg_addr_t OFS_MEM_TOP     = 4'h4;
  localparam reg_addr_t OFS_CACHED_CNT  = 4'h5;
  localparam reg_addr_t OFS_CODE_BASE   = 4'h6;
  localparam reg_addr_t OFS_INSTR_CTR   = 4'h7;
  localparam reg_addr_t OFS_OFFSET_REG  = 4'h8;
  localparam reg_addr_t OFS_STATUS      = 4'h9;
  localparam reg_addr_t OFS_TOP_ADDR    = 4'ha;
  localparam reg_addr_t OFS_COMMAND     = 4'hb;
  localparam reg_addr_t OFS_OP_STATUS   = 4'hc;
  localparam reg_addr_t OFS_DATA        = 4'hd;

  // Operation status bits.
  localparam int OPST_OVERFLOW  = 0;
  localparam int OPST_UNDERFLOW = 1;
  localparam int OPST_BUSY      = 2;

  // Command field sits in the low bits, argument in the high byte.
  localparam int CMD_LSB = 0;
  localparam int CMD_MSB = 2;
  localparam int ARG_LSB = 8;
  localparam int ARG_MSB = 15;

  typedef logic [7:0] arg_t;

  localparam logic [2:0] CMD_NOP    = 3'h0;
  localparam logic [2:0] CMD_PUSH   = 3'h1;
  localparam logic [2:0] CMD_POP    = 3'h2;
  localparam logic [2:0] CMD_FLUSH  = 3'h3;
  localparam logic [2:0] CMD_PREP   = 3'h4;
  localparam logic [2:0] CMD_CALL   = 3'h5;
  localparam logic [2:0] CMD_RETURN = 3'h6;
  localparam logic [2:0] CMD_LOADG  = 3'h7;

  // Reset values.
  localparam word_t WORD_RST  = 16'h0000;
  localparam word_t LIMIT_RST = 16'hffff;

  // One request towards main memory; read data returns one cycle later.
  typedef struct packed {
    word_t addr;
    word_t wdata;
    logic  wr;
    logic  rd;
  } mem_req_t;

endpackage : stack_pkg

// File: src/stack_pointer_and_frame_unit.sv
/*
  Stack pointer and frame unit: bounds, memory top, cached top-of-stack
  words, flush, call marker push and marker unwind on return.
  Assumes a register master on the same clock and a main memory that takes
  one request per cycle and returns read data in the following cycle.
*/
// Local design decisions: the plain strobed port and the address map.
// How it works
// - Stack lies between dyn_limit and stack_limit registers.
// - Moving mem_top past stack_limit raises trap; falling below dyn_limit only sets the underflow status bit.
// - Up to four top words held internally.
// - Three-bit cached_count never exceeds four.
// - Top address is mem_top plus cached_count.
// - Cached words have no visible address.
// - Flush writes cached words, advances mem_top, clears count.
// - Two-operand prep fetches until two cached.
// - Global displacement limited to 0 through 255.
// - proc_call pushes offset, return, status, link.
// - Saved status carries caller code segment.
// - Link is distance back; frame_base points there.
// - Return sets top to frame_base, restores previous.
// - Return steps down restoring status, counter, offset.
// - Return drops parameters by selectable amount.
`timescale 1ns/100ps
module stack_pointer_and_frame_unit
  import stack_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst_n,
  input  wire reg_addr_t reg_addr,
  input  wire word_t     reg_wdata,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  output word_t          reg_rdata,
  output mem_req_t       mem_req,
  input  wire word_t     mem_rdata,
  output logic           stack_trap,
  output logic           busy
);

  // -----------------------------------------------------------------------
  // State and storage
  // -----------------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_SPILL    = 9'h002,
    ST_FETCH    = 9'h004,
    ST_FETCH_WT = 9'h008,
    ST_FLUSH    = 9'h010,
    ST_MARK     = 9'h020,
    ST_RET_RD   = 9'h040,
    ST_RET_WT   = 9'h080,
    ST_LOAD_WT  = 9'h100
  } state_t;

  state_t           state_r;
  logic [2:0]       goal_r;
  arg_t             arg_r;
  logic [1:0]       step_r;
  word_t            dyn_limit_r;
  word_t            data_base_r;
  word_t            stack_limit_r;
  word_t            frame_base_r;
  word_t            mem_top_r;
  logic [CNT_W-1:0] cached_count_r;
  word_t            code_base_r;
  word_t            instr_ctr_r;
  word_t            offset_reg_r;
  word_t            status_r;
  word_t            data_r;
  logic             overflow_r;
  logic             underflow_r;
  word_t            rdata_r;
  mem_req_t         mem_req_r;
  logic             busy_r;
  word_t            cache_r [CACHE_DEPTH];

  // -----------------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------------
  // Actual top-of-stack address; the cached words sit just above mem_top.
  function automatic word_t top_addr_f(input word_t top, input logic [CNT_W-1:0] cnt);
    top_addr_f = top + {{(WORD_W-CNT_W){1'b0}}, cnt};
  endfunction : top_addr_f

  // True when a word placed at addr would pass the upper bound.
  function automatic logic past_limit_f(input word_t addr, input word_t limit);
    past_limit_f = (addr > limit);
  endfunction : past_limit_f

  word_t next_top;
  word_t top_addr;
  logic  cmd_wr;
  logic  idle;

  // Next memory slot above mem_top and the visible top address.
  assign next_top = mem_top_r + 16'h0001;
  assign top_addr = top_addr_f(mem_top_r, cached_count_r);
  assign idle     = (state_r == ST_IDLE);
  assign cmd_wr   = reg_wr && (reg_addr == OFS_COMMAND) && idle;

  // -----------------------------------------------------------------------
  // Cache array
  // -----------------------------------------------------------------------
  // Word 0 is the oldest cached word and belongs at mem_top + 1. Shifting
  // keeps that mapping, so spill and flush always write cache word 0.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < CACHE_DEPTH; i++) begin
        cache_r[i] <= WORD_RST;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_wr && reg_wdata[CMD_MSB:CMD_LSB] == CMD_PUSH &&
              cached_count_r != CACHE_FULL) begin
            cache_r[cached_count_r[1:0]] <= data_r;
          end
        end
        ST_SPILL, ST_FLUSH: begin
          if (!past_limit_f(next_top, stack_limit_r) &&
              (state_r == ST_SPILL || cached_count_r != 3'h0)) begin
            for (int i = 0; i < CACHE_DEPTH - 1; i++) begin
              cache_r[i] <= cache_r[i+1];
            end
            if (state_r == ST_SPILL) begin
              cache_r[CACHE_DEPTH-1] <= data_r;
            end
          end
        end
        ST_FETCH_WT: begin
          if (goal_r != CMD_POP) begin
            for (int i = 1; i < CACHE_DEPTH; i++) begin
              cache_r[i] <= cache_r[i-1];
            end
            cache_r[0] <= mem_rdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Control and pointers
  // -----------------------------------------------------------------------
  // Pointer registers are software-writable only while idle; once an
  // operation runs the sequencer owns them, which avoids torn updates.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r        <= ST_IDLE;
      goal_r         <= CMD_NOP;
      arg_r          <= 8'h00;
      step_r         <= 2'h0;
      dyn_limit_r    <= WORD_RST;
      data_base_r    <= WORD_RST;
      stack_limit_r  <= LIMIT_RST;
      frame_base_r   <= WORD_RST;
      mem_top_r      <= WORD_RST;
      cached_count_r <= 3'h0;
      code_base_r    <= WORD_RST;
      instr_ctr_r    <= WORD_RST;
      offset_reg_r   <= WORD_RST;
      status_r       <= WORD_RST;
      data_r         <= WORD_RST;
      overflow_r     <= 1'b0;
      underflow_r    <= 1'b0;
      mem_req_r      <= '0;
      busy_r         <= 1'b0;
    end else begin
      mem_req_r.wr <= 1'b0;
      mem_req_r.rd <= 1'b0;
      busy_r       <= (state_r != ST_IDLE) || cmd_wr; // Rises the cycle after the command; drops one cycle after idle.
      // Trap flags are cleared by writing ones; a set below wins.
      if (reg_wr && reg_addr == OFS_OP_STATUS && reg_wdata[OPST_OVERFLOW]) overflow_r <= 1'b0;
      if (reg_wr && reg_addr == OFS_OP_STATUS && reg_wdata[OPST_UNDERFLOW]) underflow_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (reg_wr) begin
            case (reg_addr)
              OFS_DYN_LIMIT:   dyn_limit_r   <= reg_wdata;
              OFS_DATA_BASE:   data_base_r   <= reg_wdata;
              OFS_STACK_LIMIT: stack_limit_r <= reg_wdata;
              OFS_FRAME_BASE:  frame_base_r  <= reg_wdata;
              OFS_MEM_TOP:     mem_top_r     <= reg_wdata;
              OFS_CODE_BASE:   code_base_r   <= reg_wdata;
              OFS_INSTR_CTR:   instr_ctr_r   <= reg_wdata;
              OFS_OFFSET_REG:  offset_reg_r  <= reg_wdata;
              OFS_STATUS:      status_r      <= reg_wdata;
              OFS_DATA:        data_r        <= reg_wdata;
              default: begin
              end
            endcase
          end
          if (cmd_wr) begin
            goal_r <= reg_wdata[CMD_MSB:CMD_LSB];
            arg_r  <= reg_wdata[ARG_MSB:ARG_LSB];
            step_r <= 2'h0;
            case (reg_wdata[CMD_MSB:CMD_LSB])
              CMD_PUSH: begin
                if (cached_count_r == CACHE_FULL) begin
                  state_r <= ST_SPILL;
                end else begin
                  cached_count_r <= cached_count_r + 3'h1;
                end
              end
              CMD_POP: begin
                if (cached_count_r != 3'h0) begin
                  data_r         <= cache_r[cached_count_r[1:0] - 2'h1];
                  cached_count_r <= cached_count_r - 3'h1;
                end else begin
                  state_r <= ST_FETCH;
                end
              end
              CMD_FLUSH, CMD_CALL: state_r <= ST_FLUSH;
              CMD_PREP: if (cached_count_r < OPERANDS) state_r <= ST_FETCH;
              CMD_RETURN: begin
                // Cached words belong to the callee and are discarded.
                cached_count_r <= 3'h0;
                mem_top_r      <= frame_base_r;
                state_r        <= ST_RET_RD;
              end
              CMD_LOADG: begin
                // The 8-bit displacement cannot reach past base + 255.
                mem_req_r.addr <= data_base_r + {8'h00, reg_wdata[ARG_MSB:ARG_LSB]};
                mem_req_r.rd   <= 1'b1;
                state_r        <= ST_LOAD_WT;
              end
              default: begin
              end
            endcase
          end
        end
        ST_SPILL: begin
          // Full cache: the oldest word goes out so the new one fits.
          if (past_limit_f(next_top, stack_limit_r)) begin
            overflow_r <= 1'b1;
          end else begin
            mem_req_r.addr  <= next_top;
            mem_req_r.wdata <= cache_r[0];
            mem_req_r.wr    <= 1'b1;
            mem_top_r       <= next_top;
          end
          state_r <= ST_IDLE;
        end
        ST_FETCH: begin
          if (mem_top_r < dyn_limit_r) begin
            underflow_r <= 1'b1;
            state_r     <= ST_IDLE;
          end else begin
            mem_req_r.addr <= mem_top_r;
            mem_req_r.rd   <= 1'b1;
            state_r        <= ST_FETCH_WT;
          end
        end
        ST_FETCH_WT: begin
          mem_top_r <= mem_top_r - 16'h0001;
          if (goal_r == CMD_POP) begin
            data_r  <= mem_rdata;
            state_r <= ST_IDLE;
          end else begin
            cached_count_r <= cached_count_r + 3'h1;
            state_r <= (cached_count_r + 3'h1 < OPERANDS) ? ST_FETCH : ST_IDLE;
          end
        end
        ST_FLUSH: begin
          // One word per cycle to its matching address above mem_top.
          if (cached_count_r == 3'h0) begin
            state_r <= (goal_r == CMD_CALL) ? ST_MARK : ST_IDLE;
          end else if (past_limit_f(next_top, stack_limit_r)) begin
            overflow_r <= 1'b1;
            state_r    <= ST_IDLE;
          end else begin
            mem_req_r.addr  <= next_top;
            mem_req_r.wdata <= cache_r[0];
            mem_req_r.wr    <= 1'b1;
            mem_top_r       <= next_top;
            cached_count_r  <= cached_count_r - 3'h1;
          end
        end
        ST_MARK: begin
          if (past_limit_f(next_top, stack_limit_r)) begin
            overflow_r <= 1'b1;
            state_r    <= ST_IDLE;
          end else begin
            mem_req_r.addr <= next_top;
            mem_req_r.wr   <= 1'b1;
            mem_top_r      <= next_top;
            step_r         <= step_r + 2'h1;
            case (step_r)
              2'h0: mem_req_r.wdata <= offset_reg_r;
              2'h1: mem_req_r.wdata <= instr_ctr_r + 16'h0001 - code_base_r;
              2'h2: mem_req_r.wdata <= status_r;
              default: begin
                mem_req_r.wdata <= next_top - frame_base_r;
                frame_base_r    <= next_top;
                state_r         <= ST_IDLE;
              end
            endcase
          end
        end
        ST_RET_RD: begin
          mem_req_r.addr <= mem_top_r;
          mem_req_r.rd   <= 1'b1;
          state_r        <= ST_RET_WT;
        end
        ST_RET_WT: begin
          // Marker words come back top down: link, status, return, offset.
          case (step_r)
            2'h0: frame_base_r <= frame_base_r - mem_rdata;
            2'h1: status_r     <= mem_rdata;
            2'h2: instr_ctr_r  <= mem_rdata + code_base_r;
            default: offset_reg_r <= mem_rdata;
          endcase
          if (step_r == MARK_LAST) begin
            mem_top_r <= mem_top_r - 16'h0001 - {8'h00, arg_r};
            state_r   <= ST_IDLE;
          end else begin
            mem_top_r <= mem_top_r - 16'h0001;
            step_r    <= step_r + 2'h1;
            state_r   <= ST_RET_RD;
          end
        end
        ST_LOAD_WT: begin
          data_r  <= mem_rdata;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Register read port
  // -----------------------------------------------------------------------
  // Read data stands one cycle after the strobe; unmapped offsets read 0.
  always_ff @(posedge clock) begin
    if (!rst_n || !reg_rd) begin
      rdata_r <= WORD_RST;
    end else begin
      case (reg_addr)
        OFS_DYN_LIMIT:   rdata_r <= dyn_limit_r;
        OFS_DATA_BASE:   rdata_r <= data_base_r;
        OFS_STACK_LIMIT: rdata_r <= stack_limit_r;
        OFS_FRAME_BASE:  rdata_r <= frame_base_r;
        OFS_MEM_TOP:     rdata_r <= mem_top_r;
        OFS_CACHED_CNT:  rdata_r <= {13'h0000, cached_count_r};
        OFS_CODE_BASE:   rdata_r <= code_base_r;
        OFS_INSTR_CTR:   rdata_r <= instr_ctr_r;
        OFS_OFFSET_REG:  rdata_r <= offset_reg_r;
        OFS_STATUS:      rdata_r <= status_r;
        OFS_TOP_ADDR:    rdata_r <= top_addr;
        OFS_OP_STATUS:   rdata_r <= {13'h0000, !idle, underflow_r, overflow_r};
        OFS_DATA:        rdata_r <= data_r;
        default:         rdata_r <= WORD_RST;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // Every port is a plain copy of a flop, so nothing combinational leaks out.
  assign reg_rdata  = rdata_r;
  assign mem_req    = mem_req_r;
  assign stack_trap = overflow_r;
  assign busy       = busy_r;

endmodule : stack_pointer_and_frame_unit

// File: dv/stack_pointer_and_frame_unit_checker.sv
/*
  Port checker for the stack pointer and frame unit, bound to its top.
  Assumes limit and base writes are made while the sequencer is idle.
*/
`timescale 1ns/100ps
module stack_pointer_and_frame_unit_checker
  import stack_pkg::*;
(
  input wire logic      clock,
  input wire logic      rst_n,
  input wire reg_addr_t reg_addr,
  input wire word_t     reg_wdata,
  input wire logic      reg_wr,
  input wire logic      reg_rd,
  input wire word_t     reg_rdata,
  input wire mem_req_t  mem_req,
  input wire word_t     mem_rdata,
  input wire logic      stack_trap,
  input wire logic      busy
);
  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  word_t      limit_r;
  word_t      base_r;
  arg_t       disp_r;
  logic       cmd_d_r;
  logic [7:0] busy_cnt_r;
  logic       cmd_wr;
  logic       clr;

  // A command counts only when the sequencer can take it.
  assign cmd_wr = reg_wr && reg_addr == OFS_COMMAND && !busy && !cmd_d_r;
  assign clr    = reg_wr && reg_addr == OFS_OP_STATUS && reg_wdata[OPST_OVERFLOW];

  // Shadows follow accepted writes only, so they match the unit's own copies.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      limit_r <= LIMIT_RST;
      base_r  <= WORD_RST;
      disp_r  <= 8'h00;
      cmd_d_r <= 1'b0;
    end else begin
      cmd_d_r <= reg_wr && reg_addr == OFS_COMMAND;
      if (reg_wr && !busy && !cmd_d_r && reg_addr == OFS_STACK_LIMIT) limit_r <= reg_wdata;
      if (reg_wr && !busy && !cmd_d_r && reg_addr == OFS_DATA_BASE) base_r <= reg_wdata;
      if (cmd_wr) disp_r <= reg_wdata[ARG_MSB:ARG_LSB];
    end
  end

  // Length of the current busy stretch; a hung sequencer shows up here.
  always_ff @(posedge clock) begin
    if (!rst_n || !busy) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= busy_cnt_r + 8'h01;
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence call_go;
    cmd_wr && reg_wdata[CMD_MSB:CMD_LSB] == CMD_CALL;
  endsequence
  sequence ret_go;
    cmd_wr && reg_wdata[CMD_MSB:CMD_LSB] == CMD_RETURN;
  endsequence
  sequence loadg_go;
    cmd_wr && reg_wdata[CMD_MSB:CMD_LSB] == CMD_LOADG;
  endsequence
  sequence marker_writes;
    mem_req.wr [*4];
  endsequence

  AST_WR_IN_LIMIT: assert property (mem_req.wr |-> mem_req.addr <= limit_r)
    else $error("memory write above the stack limit");
  AST_ONE_REQ: assert property (!(mem_req.wr && mem_req.rd))
    else $error("read and write requested together");
  AST_TRAP_STICKY: assert property (stack_trap && !clr |=> stack_trap)
    else $error("trap dropped without a clear");
  AST_TRAP_CLEAR: assert property (clr && !busy && !cmd_d_r |=> !stack_trap)
    else $error("trap not cleared by write one");
  AST_BUSY_START: assert property (
    cmd_wr && reg_wdata[CMD_MSB:CMD_LSB] != CMD_NOP |-> ##[1:2] busy)
    else $error("busy did not follow a command");
  AST_BUSY_BOUND: assert property (busy_cnt_r < 8'd60)
    else $error("sequencer stayed busy too long");
  AST_CALL_MARK: assert property (call_go |-> ##[2:16] marker_writes)
    else $error("call wrote no four word marker");
  AST_RET_READ: assert property (ret_go |-> ##[2:8] mem_req.rd)
    else $error("return read no frame link");
  AST_LOADG_ADDR: assert property (loadg_go |-> ##[1:3]
    (mem_req.rd && mem_req.addr == base_r + {8'h00, disp_r}))
    else $error("global load read a wrong address");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == WORD_RST)
    else $error("read data outside the answer cycle");
endmodule : stack_pointer_and_frame_unit_checker

bind stack_pointer_and_frame_unit stack_pointer_and_frame_unit_checker
  stack_pointer_and_frame_unit_checker_inst (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .stack_trap(stack_trap), .busy(busy));

// File: dv/stack_mem_model.sv
/*
  Main memory behind the stack unit: one request a cycle, no wait.
  Assumes the unit's registered request struct on the same clock.
*/
`timescale 1ns/100ps
module stack_mem_model
  import stack_pkg::*;
(
  input  wire logic     clock,
  input  wire mem_req_t mem_req,
  output word_t         mem_rdata
);
  word_t mem [0:65535];
  word_t q_r;

  // Each word starts as its address xor a pattern, so fetches are predictable.
  initial begin
    q_r = 16'h0000;
    for (int a = 0; a < 65536; a++) mem[a] = word_t'(a) ^ 16'h5a5a;
  end

  // The unit's request is already a flop, so a read answers while it stands.
  always @(posedge clock) begin
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.rd) q_r <= mem[mem_req.addr];
  end
  // Between reads the inverse of the last answer shows, so stale data fails.
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~q_r;
endmodule : stack_mem_model

// File: dv/stack_pointer_and_frame_unit_tb.sv
/*
  Self-checking bench for the stack pointer and frame unit.
  Assumes the memory model answers every read in the following cycle.
*/
`timescale 1ns/100ps
module stack_pointer_and_frame_unit_tb
  import stack_pkg::*;
;
  logic      clock = 1'b0;
  logic      rst_n = 1'b0;
  reg_addr_t reg_addr = 4'h0;
  word_t     reg_wdata = 16'h0000;
  logic      reg_wr = 1'b0;
  logic      reg_rd = 1'b0;
  word_t     reg_rdata;
  mem_req_t  mem_req;
  word_t     mem_rdata;
  logic      stack_trap;
  logic      busy;
  int        err_total = 0;
  int        n_compared = 0;

  always #20 clock = ~clock;

  stack_pointer_and_frame_unit stack_pointer_and_frame_unit_inst (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .stack_trap(stack_trap), .busy(busy));
  stack_mem_model stack_mem_model_inst (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input word_t seen, input word_t exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input reg_addr_t a, input word_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // A free edge keeps the next strobe out of this time step.
    @(posedge clock);
  endtask : wr

  // Read data is taken mid-cycle, clear of the edge that retires it.
  task automatic rchk(input reg_addr_t a, input word_t e);
    word_t d;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
    chk(d, e);
  endtask : rchk

  task automatic cmd(input logic [2:0] c, input arg_t g);
    int n;
    wr(OFS_COMMAND, {g, 5'h00, c});
    n = 0;
    repeat (2) @(posedge clock);
    // Busy is judged mid-cycle, clear of the edge that updates it.
    @(negedge clock);
    while (busy !== 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    if (n >= 100) err_total++;
  endtask : cmd

  task automatic push(input word_t v);
    wr(OFS_DATA, v);
    cmd(CMD_PUSH, 8'h00);
  endtask : push

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 16; i++) begin
      if (i != 11) rchk(reg_addr_t'(i), (i == 2) ? LIMIT_RST : WORD_RST);
    end
    wr(OFS_DYN_LIMIT, 16'h0010);
    wr(OFS_DATA_BASE, 16'h0020);
    wr(OFS_STACK_LIMIT, 16'h01ff);
    wr(OFS_FRAME_BASE, 16'h0100);
    wr(OFS_MEM_TOP, 16'h0100);
    wr(OFS_CACHED_CNT, 16'h0003);
    wr(4'he, 16'h1234);
    rchk(OFS_DYN_LIMIT, 16'h0010);
    rchk(OFS_STACK_LIMIT, 16'h01ff);
    rchk(OFS_CACHED_CNT, 16'h0000);
    rchk(OFS_TOP_ADDR, 16'h0100);
    rchk(4'he, 16'h0000);
  endtask : t_regs

  task automatic t_cache;
    for (int i = 0; i < 5; i++) begin
      push(16'h00a0 + word_t'(i));
      if (i == 3) rchk(OFS_TOP_ADDR, 16'h0104);
    end
    chk(stack_mem_model_inst.mem[16'h0101], 16'h00a0);
    rchk(OFS_CACHED_CNT, 16'h0004);
    rchk(OFS_TOP_ADDR, 16'h0105);
    cmd(CMD_FLUSH, 8'h00);
    rchk(OFS_CACHED_CNT, 16'h0000);
    rchk(OFS_MEM_TOP, 16'h0105);
    for (int i = 1; i < 5; i++) begin
      chk(stack_mem_model_inst.mem[16'h0101 + i], 16'h00a0 + word_t'(i));
    end
    cmd(CMD_PREP, 8'h00);
    rchk(OFS_CACHED_CNT, 16'h0002);
    rchk(OFS_MEM_TOP, 16'h0103);
    cmd(CMD_POP, 8'h00);
    rchk(OFS_DATA, 16'h00a4);
    cmd(CMD_POP, 8'h00);
    rchk(OFS_DATA, 16'h00a3);
    cmd(CMD_POP, 8'h00);
    rchk(OFS_DATA, 16'h00a2);
    rchk(OFS_MEM_TOP, 16'h0102);
    cmd(CMD_PUSH, 8'h00);
    rchk(OFS_TOP_ADDR, 16'h0103);
  endtask : t_cache

  task automatic t_global;
    cmd(CMD_LOADG, 8'hff);
    rchk(OFS_DATA, 16'h011f ^ 16'h5a5a);
    cmd(CMD_LOADG, 8'h00);
    rchk(OFS_DATA, 16'h0020 ^ 16'h5a5a);
  endtask : t_global

  // Two parameters are still cached at the call, so the flush comes first.
  task automatic t_frame;
    word_t exp [6];
    exp = '{16'h0011, 16'h0022, 16'h0aaa, 16'h0031, 16'h0c05, 16'h0009};
    push(16'h0011);
    push(16'h0022);
    wr(OFS_OFFSET_REG, 16'h0aaa);
    wr(OFS_CODE_BASE, 16'h0200);
    wr(OFS_INSTR_CTR, 16'h0230);
    wr(OFS_STATUS, 16'h0c05);
    cmd(CMD_CALL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      chk(stack_mem_model_inst.mem[16'h0104 + i], exp[i]);
    end
    rchk(OFS_FRAME_BASE, 16'h0109);
    rchk(OFS_TOP_ADDR, 16'h0109);
    wr(OFS_OFFSET_REG, 16'h0000);
    wr(OFS_INSTR_CTR, 16'h0000);
    wr(OFS_STATUS, 16'h0000);
    push(16'h0077);
    cmd(CMD_RETURN, 8'h01);
    rchk(OFS_FRAME_BASE, 16'h0100);
    rchk(OFS_STATUS, 16'h0c05);
    rchk(OFS_INSTR_CTR, 16'h0231);
    rchk(OFS_OFFSET_REG, 16'h0aaa);
    rchk(OFS_TOP_ADDR, 16'h0104);
  endtask : t_frame

  // The fifth push must spill past the limit, so it is dropped and traps.
  task automatic t_trap;
    wr(OFS_STACK_LIMIT, 16'h0104);
    for (int i = 0; i < 5; i++) push(16'h00b0 + word_t'(i));
    chk({15'h0000, stack_trap}, 16'h0001);
    rchk(OFS_OP_STATUS, 16'h0001);
    chk(stack_mem_model_inst.mem[16'h0105], 16'h0022);
    rchk(OFS_MEM_TOP, 16'h0104);
    wr(OFS_OP_STATUS, 16'h0001);
    @(posedge clock);
    chk({15'h0000, stack_trap}, 16'h0000);
  endtask : t_trap

  task automatic wrap_up;
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Whole run takes well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_cache();
    t_global();
    t_frame();
    t_trap();
    wrap_up();
  end
endmodule : stack_pointer_and_frame_unit_tb
